// ### pcfd_pkg.sv
`default_nettype none
package pcfd_pkg;
  localparam int PCFD_AW = 8;
  localparam int PCFD_DW = 32;
  localparam int PCFD_NW = 18;
  // register byte offsets
  localparam logic [PCFD_AW-1:0] PCFD_OFF_CTRL = 8'h00;
  localparam logic [PCFD_AW-1:0] PCFD_OFF_NDIV = 8'h04;
  localparam logic [PCFD_AW-1:0] PCFD_OFF_STAT = 8'h08;
  localparam logic [PCFD_AW-1:0] PCFD_OFF_TOTAL = 8'h0c;
  // control register fields
  localparam int PCFD_CTRL_SLEEP = 0;
  localparam int PCFD_CTRL_ALLEN = 1;
  localparam int PCFD_CTRL_FLOAT = 2;
  localparam int PCFD_CTRL_POL = 3;
  localparam int PCFD_CTRL_GAIN = 4;
  localparam int PCFD_CTRL_SEL = 8;
  localparam int PCFD_CTRL_POE = 16;
  // status register fields
  localparam int PCFD_STAT_DLOCK = 0;
  localparam int PCFD_STAT_ALOCK = 1;
  localparam int PCFD_STAT_BADSEL = 2;
  localparam int PCFD_STAT_BADN = 3;
  localparam int PCFD_STAT_ACTIVE = 4;
  localparam int PCFD_STAT_GOE = 5;
  // reset values
  localparam logic PCFD_RST_SLEEP = 1'b0;
  localparam logic PCFD_RST_ALLEN = 1'b1;
  localparam logic PCFD_RST_FLOAT = 1'b0;
  localparam logic PCFD_RST_POL = 1'b0;
  localparam logic [1:0] PCFD_RST_GAIN = 2'h0;
  localparam logic [3:0] PCFD_RST_SEL = 4'h0;
  localparam logic [PCFD_NW-1:0] PCFD_RST_NDIV = 18'h002f8;
  // pump current multipliers per gain code
  localparam logic [5:0] PCFD_GAIN_X1 = 6'h01;
  localparam logic [5:0] PCFD_GAIN_X4 = 6'h04;
  localparam logic [5:0] PCFD_GAIN_X16 = 6'h10;
  localparam logic [5:0] PCFD_GAIN_X32 = 6'h20;

  typedef enum logic [3:0] {
    PCFD_LM_HIZ = 4'b0000,
    PCFD_LM_HIGH = 4'b0001,
    PCFD_LM_LOW = 4'b0010,
    PCFD_LM_DLD_H = 4'b0011,
    PCFD_LM_DLD_L = 4'b0100,
    PCFD_LM_ALD_PP = 4'b0101,
    PCFD_LM_ALD_NMOS = 4'b0110,
    PCFD_LM_ALD_PMOS = 4'b0111,
    PCFD_LM_NDIV = 4'b1001,
    PCFD_LM_RDIV = 4'b1011
  } pcfd_lmode_t;

  function automatic logic pcfd_sel_valid(input logic [3:0] sel);
    pcfd_sel_valid = (sel <= 4'h7) || (sel == 4'h9) || (sel == 4'hb);
  endfunction
endpackage
`default_nettype wire

// ### pcfd_cfg_if.sv
`timescale 1ns/1ps
`default_nettype none
interface pcfd_cfg_if;
  logic [3:0] sel;
  logic [17:0] ndiv;
  logic sleep;
  logic fb_clk;
  modport src (output sel, output ndiv, output sleep, input fb_clk);
  modport pin (input sel, input sleep, input fb_clk);
  modport div (input ndiv, input sleep, output fb_clk);
endinterface
`default_nettype wire

// ### pcfd_fb_div.sv
`timescale 1ns/1ps
`default_nettype none
module pcfd_fb_div (
  input wire logic core_clk_i, // core clock
  input wire logic rst_n_i, // sync reset, active low
  pcfd_cfg_if.div cfg, // divide value and sleep in, divided output out
  input wire logic fb_tick_i // one prescaled oscillator period
);
  import pcfd_pkg::*;
  logic [PCFD_NW-1:0] cnt_q;
  logic [PCFD_NW-1:0] cnt_d;
  logic [PCFD_NW:0] nplus;
  logic out_q;

  assign nplus = {1'b0, cfg.ndiv} + 19'h00001;

  // >= also recovers when the divide value shrinks below the count
  always_comb
  begin
    if (cnt_q >= cfg.ndiv - 18'h00001) // [R9]
      cnt_d = '0;
    else
      cnt_d = cnt_q + 18'h00001;
  end

  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i || cfg.sleep) // [R5]
    begin
      cnt_q <= '0;
      out_q <= 1'b0;
    end
    else if (fb_tick_i) // [R10]
    begin
      cnt_q <= cnt_d;
      out_q <= cnt_d < nplus[PCFD_NW:1];
    end
  end

  assign cfg.fb_clk = out_q;

  a_fb_sleep_quiet: // [R5]
  assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    cfg.sleep |=> !out_q && cnt_q == '0)
  else $error("feedback divider ran during sleep");

  a_fb_count_bound: // [R9]
  assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    fb_tick_i && !cfg.sleep |=> cnt_q < $past(cfg.ndiv))
  else $error("feedback count beyond divide value");
endmodule
`default_nettype wire

// ### pcfd_lock_pin.sv
`timescale 1ns/1ps
`default_nettype none
module pcfd_lock_pin (
  input wire logic core_clk_i, // core clock
  input wire logic rst_n_i, // sync reset, active low
  pcfd_cfg_if.pin cfg, // pin select, sleep, divided clock
  input wire logic dig_lock_i, // synced digital lock result
  input wire logic ana_lock_i, // synced analog lock indication
  input wire logic ref_div_i, // synced reference divider output
  output logic pin_o, // pin level when driven
  output logic pin_oe_o // pin driven
);
  import pcfd_pkg::*;
  pcfd_lmode_t mode;
  logic lvl_d;
  logic oe_d;

  assign mode = pcfd_lmode_t'(cfg.sel);

  always_comb
  begin
    lvl_d = 1'b0;
    oe_d = 1'b0;
    if (!cfg.sleep) // [R5]
    begin
      unique case (mode)
        PCFD_LM_HIZ: oe_d = 1'b0; // [R1]
        PCFD_LM_HIGH: // [R1]
        begin
          lvl_d = 1'b1;
          oe_d = 1'b1;
        end
        PCFD_LM_LOW: oe_d = 1'b1; // [R1]
        PCFD_LM_DLD_H: // [R2]
        begin
          lvl_d = dig_lock_i;
          oe_d = 1'b1;
        end
        PCFD_LM_DLD_L: // [R2]
        begin
          lvl_d = !dig_lock_i;
          oe_d = 1'b1;
        end
        PCFD_LM_ALD_PP: // [R3]
        begin
          lvl_d = ana_lock_i;
          oe_d = 1'b1;
        end
        PCFD_LM_ALD_NMOS: oe_d = !ana_lock_i; // [R3]
        PCFD_LM_ALD_PMOS: // [R3]
        begin
          lvl_d = 1'b1;
          oe_d = ana_lock_i;
        end
        PCFD_LM_NDIV: // [R4]
        begin
          lvl_d = cfg.fb_clk;
          oe_d = 1'b1;
        end
        PCFD_LM_RDIV: // [R4]
        begin
          lvl_d = ref_div_i;
          oe_d = 1'b1;
        end
        // forbidden codes leave the pin floating rather than guess
        default: oe_d = 1'b0; // [R4]
      endcase
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      pin_o <= 1'b0;
      pin_oe_o <= 1'b0;
    end
    else
    begin
      pin_o <= lvl_d;
      pin_oe_o <= oe_d;
    end
  end

  a_pin_hiz_sel: // [R1]
  assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    cfg.sel == 4'h0 |=> !pin_oe_o)
  else $error("lock pin driven in disabled mode");

  a_pin_dld_low: // [R2]
  assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    cfg.sel == 4'h4 && !cfg.sleep |=> pin_oe_o && pin_o == !$past(dig_lock_i))
  else $error("active low lock detect wrong");

  a_pin_nmos_od: // [R3]
  assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    cfg.sel == 4'h6 && !cfg.sleep |=> !pin_o && pin_oe_o == !$past(ana_lock_i))
  else $error("nmos open drain stage wrong");

  a_pin_bad_code: // [R4]
  assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    !pcfd_sel_valid(cfg.sel) || cfg.sleep |=> !pin_oe_o)
  else $error("lock pin driven on forbidden code");
endmodule
`default_nettype wire

// ### pcfd_top.sv
// Implementation choices: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// [R1] pin select 0 floats the lock pin; 1 drives high, 2 drives low
// [R2] select 3 shows digital lock active high, 4 active low
// [R3] selects 5, 6, 7 show analog lock: push-pull, nmos drain, pmos drain
// [R4] 9 shows feedback divider, 11 reference divider; other codes forbidden
// [R5] full sleep powers everything down, overriding all other settings; code overrides clock enables, pump float, lock pin, fb divider
// [R6] clearing all-outputs enable disables every clock output
// [R7] pump float set puts the charge pump output high impedance
// [R8] pump polarity 0 negative, 1 positive
// [R9] feedback divide is 18-bit binary, 1 to 262143, default 760, never 0
// [R10] total feedback division is divide value times oscillator divider
// [R11] pump gain codes 0..3 give 1x, 4x, 16x, 32x current
// [R12] outputs enable pin low disables all clock outputs
module pcfd_top #(
  parameter int NOUT = 4,
  parameter int VW = 5
) (
  input wire logic core_clk_i, // core clock, 125 MHz
  input wire logic rst_n_i, // sync reset, active low
  input wire logic [pcfd_pkg::PCFD_AW-1:0] reg_addr_i, // register byte address
  input wire logic [pcfd_pkg::PCFD_DW-1:0] reg_wdata_i, // write data
  input wire logic reg_wr_i, // write strobe
  input wire logic reg_rd_i, // read strobe
  output logic [pcfd_pkg::PCFD_DW-1:0] reg_rdata_o, // read data, cycle after strobe
  input wire logic outputs_enable_pin_i, // global enable pin, async
  input wire logic dig_lock_i, // digital lock detect, async
  input wire logic ana_lock_i, // analog lock detect, async
  input wire logic ref_div_pin_i, // reference divider output, async
  input wire logic fb_tick_i, // prescaled oscillator tick, core domain
  input wire logic [VW-1:0] vco_div_i, // oscillator divider value, core domain
  output logic lock_status_pin_o, // lock pin level
  output logic lock_status_pin_oe_o, // lock pin drive enable
  output logic full_sleep_o, // power down all blocks
  output logic [NOUT-1:0] clk_out_en_o, // effective clock output enables
  output logic pump_float_o, // charge pump high impedance
  output logic pump_polarity_o, // 1 positive, 0 negative
  output logic [1:0] pump_gain_select_o, // gain code
  output logic [5:0] pump_gain_mult_o, // gain multiplier value
  output logic [pcfd_pkg::PCFD_NW-1:0] fb_div_value_o, // feedback divide value
  output logic [pcfd_pkg::PCFD_NW+VW-1:0] fb_total_o // total feedback division
);
  import pcfd_pkg::*;

  localparam int NSYNC = 4;

  pcfd_cfg_if cfg ();

  logic [NSYNC-1:0] pins_in;
  logic [NSYNC-1:0] sync1_q;
  logic [NSYNC-1:0] sync2_q;
  logic goe_s;
  logic dlock_s;
  logic alock_s;
  logic rdiv_s;

  logic sleep_q;
  logic all_en_q;
  logic float_q;
  logic pol_q;
  logic [1:0] gain_q;
  logic [3:0] sel_q;
  logic [NOUT-1:0] poe_q;
  logic [PCFD_NW-1:0] ndiv_q;
  logic bad_sel_q;
  logic bad_n_q;
  logic [PCFD_DW-1:0] rd_d;
  logic [PCFD_DW-1:0] rdata_q;

  logic wr_ctrl;
  logic wr_ndiv;
  logic wr_stat;
  logic [PCFD_NW-1:0] wr_n;
  logic [3:0] wr_sel;
  logic outs_off;

  assign pins_in = {ref_div_pin_i, ana_lock_i, dig_lock_i, outputs_enable_pin_i};

  // pin inputs pass two flops before anything reads them
  for (genvar i = 0; i < NSYNC; i++)
  begin : g_sync
    always_ff @(posedge core_clk_i)
    begin
      if (!rst_n_i)
      begin
        sync1_q[i] <= 1'b0;
        sync2_q[i] <= 1'b0;
      end
      else
      begin
        sync1_q[i] <= pins_in[i];
        sync2_q[i] <= sync1_q[i];
      end
    end
  end

  assign goe_s = sync2_q[0];
  assign dlock_s = sync2_q[1];
  assign alock_s = sync2_q[2];
  assign rdiv_s = sync2_q[3];

  assign wr_ctrl = reg_wr_i && reg_addr_i == PCFD_OFF_CTRL;
  assign wr_ndiv = reg_wr_i && reg_addr_i == PCFD_OFF_NDIV;
  assign wr_stat = reg_wr_i && reg_addr_i == PCFD_OFF_STAT;
  assign wr_n = reg_wdata_i[PCFD_NW-1:0];
  assign wr_sel = reg_wdata_i[PCFD_CTRL_SEL +: 4];

  // control fields
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      sleep_q <= PCFD_RST_SLEEP;
      all_en_q <= PCFD_RST_ALLEN;
      float_q <= PCFD_RST_FLOAT;
      pol_q <= PCFD_RST_POL;
      gain_q <= PCFD_RST_GAIN;
      sel_q <= PCFD_RST_SEL; // [R1]
      poe_q <= '0;
    end
    else if (wr_ctrl)
    begin
      sleep_q <= reg_wdata_i[PCFD_CTRL_SLEEP];
      all_en_q <= reg_wdata_i[PCFD_CTRL_ALLEN];
      float_q <= reg_wdata_i[PCFD_CTRL_FLOAT];
      pol_q <= reg_wdata_i[PCFD_CTRL_POL];
      gain_q <= reg_wdata_i[PCFD_CTRL_GAIN +: 2];
      // forbidden codes are stored so software can read back its mistake
      sel_q <= wr_sel;
      poe_q <= reg_wdata_i[PCFD_CTRL_POE +: NOUT];
    end
  end

  // feedback divide value; a zero write is refused, the old value stays
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
      ndiv_q <= PCFD_RST_NDIV; // [R9]
    else if (wr_ndiv && wr_n != '0) // [R9]
      ndiv_q <= wr_n;
  end

  // sticky error flags; a new event beats a same-cycle clear
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      bad_sel_q <= 1'b0;
      bad_n_q <= 1'b0;
    end
    else
    begin
      if (wr_ctrl && !pcfd_sel_valid(wr_sel)) // [R4]
        bad_sel_q <= 1'b1;
      else if (wr_stat && reg_wdata_i[PCFD_STAT_BADSEL])
        bad_sel_q <= 1'b0;
      if (wr_ndiv && wr_n == '0) // [R9]
        bad_n_q <= 1'b1;
      else if (wr_stat && reg_wdata_i[PCFD_STAT_BADN])
        bad_n_q <= 1'b0;
    end
  end

  assign outs_off = sleep_q || !all_en_q || !goe_s; // [R5] [R6] [R12]

  // outputs toward the analog side, all registered
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      full_sleep_o <= PCFD_RST_SLEEP;
      clk_out_en_o <= '0;
      pump_float_o <= PCFD_RST_FLOAT;
      pump_polarity_o <= PCFD_RST_POL;
      pump_gain_select_o <= PCFD_RST_GAIN;
      fb_div_value_o <= PCFD_RST_NDIV;
    end
    else
    begin
      full_sleep_o <= sleep_q; // [R5]
      clk_out_en_o <= outs_off ? '0 : poe_q; // [R6] [R12]
      pump_float_o <= float_q || sleep_q; // [R7]
      pump_polarity_o <= pol_q; // [R8]
      pump_gain_select_o <= gain_q; // [R11]
      fb_div_value_o <= ndiv_q;
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
      pump_gain_mult_o <= PCFD_GAIN_X1;
    else
    begin
      unique case (gain_q) // [R11]
        2'h0: pump_gain_mult_o <= PCFD_GAIN_X1;
        2'h1: pump_gain_mult_o <= PCFD_GAIN_X4;
        2'h2: pump_gain_mult_o <= PCFD_GAIN_X16;
        2'h3: pump_gain_mult_o <= PCFD_GAIN_X32;
      endcase
    end
  end

  // product of both dividers in the loop, for software to check the plan
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
      fb_total_o <= '0;
    else
      fb_total_o <= (PCFD_NW+VW)'(ndiv_q) * (PCFD_NW+VW)'(vco_div_i); // [R10]
  end

  // register read mux; unmapped addresses read zero
  always_comb
  begin
    rd_d = '0;
    unique case (reg_addr_i)
      PCFD_OFF_CTRL:
      begin
        rd_d[PCFD_CTRL_SLEEP] = sleep_q;
        rd_d[PCFD_CTRL_ALLEN] = all_en_q;
        rd_d[PCFD_CTRL_FLOAT] = float_q;
        rd_d[PCFD_CTRL_POL] = pol_q;
        rd_d[PCFD_CTRL_GAIN +: 2] = gain_q;
        rd_d[PCFD_CTRL_SEL +: 4] = sel_q;
        rd_d[PCFD_CTRL_POE +: NOUT] = poe_q;
      end
      PCFD_OFF_NDIV: rd_d[PCFD_NW-1:0] = ndiv_q;
      PCFD_OFF_STAT:
      begin
        rd_d[PCFD_STAT_DLOCK] = dlock_s;
        rd_d[PCFD_STAT_ALOCK] = alock_s;
        rd_d[PCFD_STAT_BADSEL] = bad_sel_q;
        rd_d[PCFD_STAT_BADN] = bad_n_q;
        rd_d[PCFD_STAT_ACTIVE] = |clk_out_en_o;
        rd_d[PCFD_STAT_GOE] = goe_s;
      end
      PCFD_OFF_TOTAL: rd_d[PCFD_NW+VW-1:0] = fb_total_o;
      default: rd_d = '0;
    endcase
  end

  // data stand only in the cycle after the strobe
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
      rdata_q <= '0;
    else if (reg_rd_i)
      rdata_q <= rd_d;
    else
      rdata_q <= '0;
  end

  assign reg_rdata_o = rdata_q;

  assign cfg.sel = sel_q;
  assign cfg.ndiv = ndiv_q;
  assign cfg.sleep = sleep_q;

  pcfd_lock_pin u_lock_pin (
    .core_clk_i (core_clk_i),
    .rst_n_i (rst_n_i),
    .cfg (cfg.pin),
    .dig_lock_i (dlock_s),
    .ana_lock_i (alock_s),
    .ref_div_i (rdiv_s),
    .pin_o (lock_status_pin_o),
    .pin_oe_o (lock_status_pin_oe_o)
  );

  pcfd_fb_div u_fb_div (
    .core_clk_i (core_clk_i),
    .rst_n_i (rst_n_i),
    .cfg (cfg.div),
    .fb_tick_i (fb_tick_i)
  );

  a_sleep_all_off: // [R5]
  assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    full_sleep_o |-> clk_out_en_o == '0 && pump_float_o && !lock_status_pin_oe_o)
  else $error("blocks active during full sleep");

  a_global_en_off: // [R6]
  assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    !all_en_q |=> clk_out_en_o == '0)
  else $error("clock output on with global enable clear");

  a_goe_pin_off: // [R12]
  assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    !outputs_enable_pin_i ##1 !outputs_enable_pin_i ##1 !outputs_enable_pin_i
    |=> clk_out_en_o == '0)
  else $error("clock output on with enable pin low");

  a_float_write: // [R7]
  assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    wr_ctrl && reg_wdata_i[PCFD_CTRL_FLOAT] |-> ##2 pump_float_o)
  else $error("pump float not applied");

  a_pol_write: // [R8]
  assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    wr_ctrl ##1 !wr_ctrl |=> pump_polarity_o == $past(reg_wdata_i[PCFD_CTRL_POL], 2))
  else $error("pump polarity not applied");

  a_ndiv_zero_kept: // [R9]
  assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    wr_ndiv && wr_n == '0 |=> $stable(ndiv_q) && bad_n_q)
  else $error("zero divide value accepted");

  a_total_product: // [R10]
  assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    $stable(ndiv_q) && $stable(vco_div_i)
    |=> fb_total_o == (PCFD_NW+VW)'($past(ndiv_q)) * (PCFD_NW+VW)'($past(vco_div_i)))
  else $error("total feedback division wrong");

  a_gain_top_code: // [R11]
  assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    wr_ctrl && reg_wdata_i[PCFD_CTRL_GAIN +: 2] == 2'h3 ##1 !wr_ctrl
    |=> pump_gain_mult_o == 6'h20)
  else $error("32x gain not applied");
endmodule
`default_nettype wire

// ### tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin mismatches++; $display("[ERR] %0t got %0h exp %0h", $time, (g), (e)); end end
module tb;
  import pcfd_pkg::*;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [PCFD_AW-1:0] addr = 8'h00;
  logic [PCFD_DW-1:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [PCFD_DW-1:0] rdata;
  logic oe_pin = 1'b1;
  logic dig = 1'b0;
  logic ana = 1'b0;
  logic ref_pin = 1'b0;
  logic tick = 1'b0;
  logic [4:0] vco_div = 5'h01;
  logic lpin, lpin_oe, sleep, flt, pol;
  logic [3:0] clk_en;
  logic [1:0] gsel;
  logic [5:0] gmult;
  logic [PCFD_NW-1:0] nval;
  logic [PCFD_NW+4:0] ntot;
  logic [PCFD_DW-1:0] v;
  int mismatches = 0;
  int tests_run = 0;
  int hi;

  always #4 core_clk = ~core_clk;

  pcfd_top #(.NOUT(4), .VW(5)) DUT (
    .core_clk_i(core_clk), .rst_n_i(rst_n), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .outputs_enable_pin_i(oe_pin),
    .dig_lock_i(dig), .ana_lock_i(ana), .ref_div_pin_i(ref_pin), .fb_tick_i(tick),
    .vco_div_i(vco_div), .lock_status_pin_o(lpin), .lock_status_pin_oe_o(lpin_oe),
    .full_sleep_o(sleep), .clk_out_en_o(clk_en), .pump_float_o(flt),
    .pump_polarity_o(pol), .pump_gain_select_o(gsel), .pump_gain_mult_o(gmult),
    .fb_div_value_o(nval), .fb_total_o(ntot)
  );

  function automatic logic [31:0] ctrl(input logic slp, input logic all_en, input logic fl,
                                       input logic pl, input logic [1:0] g,
                                       input logic [3:0] s, input logic [3:0] poe);
    ctrl = 32'h0;
    ctrl[PCFD_CTRL_SLEEP] = slp;
    ctrl[PCFD_CTRL_ALLEN] = all_en;
    ctrl[PCFD_CTRL_FLOAT] = fl;
    ctrl[PCFD_CTRL_POL] = pl;
    ctrl[PCFD_CTRL_GAIN +: 2] = g;
    ctrl[PCFD_CTRL_SEL +: 4] = s;
    ctrl[PCFD_CTRL_POE +: 4] = poe;
  endfunction

  // expected drive enable and level of the lock pin for a select code and input level
  function automatic logic exp_oe(input logic [3:0] s, input logic k);
    case (s)
      4'h0: exp_oe = 1'b0;
      4'h6: exp_oe = !k;
      4'h7: exp_oe = k;
      4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h9, 4'hb: exp_oe = 1'b1;
      default: exp_oe = 1'b0;
    endcase
  endfunction

  function automatic logic exp_lv(input logic [3:0] s, input logic k);
    case (s)
      4'h1, 4'h7: exp_lv = 1'b1;
      4'h3, 4'h5, 4'hb: exp_lv = k;
      4'h4: exp_lv = !k;
      default: exp_lv = 1'b0;
    endcase
  endfunction

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge core_clk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge core_clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  // extra cycles cover the two sync flops on the pin inputs
  task automatic settle(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  // pin inputs change on a rising edge, like every other stimulus
  task automatic set_pins(input logic lk, input logic en);
    @(posedge core_clk);
    dig <= lk;
    ana <= lk;
    ref_pin <= lk;
    oe_pin <= en;
  endtask

  task automatic report_and_stop;
    $display("mismatches %0d tests_run %0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0)
    begin
      $display("ALL CHECKS OK");
    end
    else
    begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge core_clk);
    mismatches++;
    report_and_stop();
  end

  initial
  begin
    repeat (12) @(posedge core_clk);
    rst_n <= 1'b1;
    settle(1);
    `CHK(lpin_oe, 1'b0)
    `CHK(sleep, 1'b0)
    `CHK(flt, 1'b0)
    `CHK(pol, 1'b0)
    `CHK(gmult, 6'h01)
    `CHK(nval, 18'd760)
    rd_reg(PCFD_OFF_CTRL, v);
    `CHK(v, 32'h00000002)
    rd_reg(PCFD_OFF_NDIV, v);
    `CHK(v, 32'h000002f8)
    rd_reg(8'h10, v);
    `CHK(v, 32'h0)
    // every gain code with float and polarity toggled alongside
    for (int g = 0; g < 4; g++)
    begin
      wr_reg(PCFD_OFF_CTRL, ctrl(1'b0, 1'b1, g[0], g[1], g[1:0], 4'h0, 4'h0));
      settle(2);
      `CHK(gsel, g[1:0])
      `CHK(gmult, g == 0 ? 6'h01 : g == 1 ? 6'h04 : g == 2 ? 6'h10 : 6'h20)
      `CHK(flt, g[0])
      `CHK(pol, g[1])
    end
    // all select codes with lock inputs low and high
    for (int s = 0; s < 16; s++)
    begin
      for (int k = 0; k < 2; k++)
      begin
        set_pins(k[0], 1'b1);
        wr_reg(PCFD_OFF_CTRL, ctrl(1'b0, 1'b1, 1'b0, 1'b0, 2'h0, s[3:0], 4'h0));
        settle(5);
        `CHK(lpin_oe, exp_oe(s[3:0], k[0]))
        if (exp_oe(s[3:0], k[0]) && s != 9)
          `CHK(lpin, exp_lv(s[3:0], k[0]))
        rd_reg(PCFD_OFF_STAT, v);
        `CHK(v[PCFD_STAT_DLOCK], k[0])
        `CHK(v[PCFD_STAT_ALOCK], k[0])
        if (s < 8)
          `CHK(v[PCFD_STAT_BADSEL], 1'b0)
        else if (s == 8 || s == 10 || s >= 12)
          `CHK(v[PCFD_STAT_BADSEL], 1'b1)
      end
    end
    wr_reg(PCFD_OFF_STAT, 32'h4);
    rd_reg(PCFD_OFF_STAT, v);
    `CHK(v[PCFD_STAT_BADSEL], 1'b0)
    // global enable bit and pin both override the per-output bits
    wr_reg(PCFD_OFF_CTRL, ctrl(1'b0, 1'b1, 1'b0, 1'b0, 2'h0, 4'h1, 4'ha));
    settle(2);
    `CHK(clk_en, 4'ha)
    wr_reg(PCFD_OFF_CTRL, ctrl(1'b0, 1'b0, 1'b0, 1'b0, 2'h0, 4'h1, 4'ha));
    settle(2);
    `CHK(clk_en, 4'h0)
    wr_reg(PCFD_OFF_CTRL, ctrl(1'b0, 1'b1, 1'b0, 1'b0, 2'h0, 4'h1, 4'hf));
    set_pins(1'b1, 1'b0);
    settle(5);
    `CHK(clk_en, 4'h0)
    set_pins(1'b1, 1'b1);
    settle(5);
    `CHK(clk_en, 4'hf)
    // sleep beats the clock output enables, the pump float setting and the lock pin select
    wr_reg(PCFD_OFF_CTRL, ctrl(1'b1, 1'b1, 1'b0, 1'b0, 2'h0, 4'h1, 4'hf));
    settle(2);
    `CHK(sleep, 1'b1)
    `CHK(clk_en, 4'h0)
    `CHK(flt, 1'b1)
    `CHK(lpin_oe, 1'b0)
    // divide value extremes, zero refused, product with oscillator divider
    wr_reg(PCFD_OFF_NDIV, 32'h0003ffff);
    vco_div <= 5'd3;
    settle(3);
    `CHK(nval, 18'h3ffff)
    `CHK(ntot, 23'd786429)
    rd_reg(PCFD_OFF_TOTAL, v);
    `CHK(v, 32'd786429)
    wr_reg(PCFD_OFF_NDIV, 32'h1);
    wr_reg(PCFD_OFF_NDIV, 32'h0);
    settle(3);
    `CHK(nval, 18'h1)
    rd_reg(PCFD_OFF_STAT, v);
    `CHK(v[PCFD_STAT_BADN], 1'b1)
    // feedback divider on the pin: high for ceil(n/2) of every n ticks
    for (int n = 3; n < 5; n++)
    begin
      wr_reg(PCFD_OFF_NDIV, n);
      wr_reg(PCFD_OFF_CTRL, ctrl(1'b0, 1'b1, 1'b0, 1'b0, 2'h0, 4'h9, 4'h0));
      tick <= 1'b1;
      settle(20);
      hi = 0;
      repeat (12 * n)
      begin
        @(posedge core_clk);
        #1;
        hi += (lpin === 1'b1) ? 1 : 0;
      end
      `CHK(hi, 12 * ((n + 1) / 2))
      `CHK(lpin_oe, 1'b1)
    end
    report_and_stop();
  end
endmodule
`default_nettype wire
